// ==== sim/tmc_cfg_asserts.sv ====
// Checker for the timer mode configuration block
`timescale 1ns/1ps
module tmc_cfg_asserts
  import tmc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire tmc_ctrl_s   ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read lost");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write reply dropped");
  a_write_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready) && $past(!s_axi_wready))
    else $error("reply without request");
  a_count_excl: assert property (ctrl.highCountEnable |-> !ctrl.highCaptureEnable && !ctrl.highCompareMode)
    else $error("count mode clash");
  a_count_edge: assert property (ctrl.highCountEnable |-> ctrl.countRising || ctrl.countFalling)
    else $error("count with no edge");
  a_low_cmp: assert property (ctrl.highCompareMode |-> ctrl.lowCompareMode)
    else $error("low byte not compare");
  a_cap_excl: assert property (ctrl.highCaptureEnable |-> !ctrl.highCompareMode) else $error("capture clash");
endmodule : tmc_cfg_asserts
bind tmc_timer_mode_configuration tmc_cfg_asserts chk (
  .ref_clk(ref_clk), .resetn(resetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .ctrl(ctrl)
);

// ==== sim/tmc_testbench.sv ====
// Testbench for the timer mode configuration block
`timescale 1ns/1ps
module testbench import tmc_pkg::*;;
  logic ref_clk = 0, resetn = 0, slowClock = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, c;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  tmc_ctrl_s ctrl;
  int numErrors = 0, nCompared = 0, cnt, lag = 0;
  tmc_timer_mode_configuration uut (
    .ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .slowClock(slowClock), .ctrl(ctrl)
  );
  always #25 ref_clk = ~ref_clk;
  always begin
    repeat (4) @(posedge ref_clk);
    slowClock <= ~slowClock;
  end
  task results();
    $display("errors %0d compared %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= (lag == 0);
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      k++;
      if (k == lag) s_axi_bready <= 1;
    end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= (lag == 0);
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      k++;
      if (k == lag) s_axi_rready <= 1;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    got = s_axi_rdata; resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  function logic [7:0] ex(input logic [7:0] v);
    logic m, z;
    m = v[0];
    z = v[2:1] == 2'b00;
    return {m & !z, !m & !z, !m & z, v[3] | (!m & z), v[1], v[2], 1'b0, v[7]};
  endfunction : ex
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    results();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1;
    rd(8'h3c); chk("cfg", 0, got); chk("rresp", 0, resp);
    rd(8'h40); chk("ctrl", 8'h30, got & 8'hfd);
    for (int i = 0; i < 16; i++) begin
      c = {i[1], 3'h0, i[3:0]};
      wr(8'h3c, {24'h0, c}, 4'h1); chk("bresp", 0, resp);
      rd(8'h3c); chk("cfg", c, got);
      rd(8'h40); chk("ctrl", ex(c) & 8'hfd, got & 8'hfd);
    end
    lag = 3;
    wr(8'h3c, {24'h0, c}, 4'h1); chk("lag bresp", 0, resp);
    rd(8'h3c); chk("lag cfg", c, got);
    lag = 0;
    wr(8'h3c, 32'h0000_00ff, 4'h0); rd(8'h3c); chk("strobe", c, got);
    wr(8'h40, 32'h0000_0000, 4'hf); chk("status wr", 0, resp);
    wr(8'h44, 32'h0000_0000, 4'hf); chk("bad wr", 2, resp);
    rd(8'h44); chk("bad rd", 2, resp);
    for (int d = 0; d < 8; d++) begin
      wr(8'h3c, d << 4, 4'h1);
      repeat (2) @(posedge ref_clk);
      do @(posedge ref_clk); while (ctrl.timerTick !== 1'b1);
      cnt = 0;
      do begin
        @(posedge ref_clk);
        cnt++;
      end while (ctrl.timerTick !== 1'b1);
      chk("tick", 1 << d, cnt);
    end
    wr(8'h3c, 32'h0000_0080, 4'h1);
    repeat (8) @(posedge ref_clk);
    cnt = 0;
    repeat (80) begin
      @(posedge ref_clk);
      cnt += ctrl.timerTick;
    end
    chk("alt", 10, cnt);
    resetn <= 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    rd(8'h3c); chk("cfg", 0, got);
    rd(8'h40); chk("ctrl", 8'h30, got & 8'hfd);
    results();
  end
endmodule : testbench

// ==== src/tmc_consts.svh ====
// Offsets, field positions, reset values and timing counts for the timer mode configuration block
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_CFG_INDEX       8'h0f
`define TMC_CFG_ADDR        8'h3c
`define TMC_STATUS_ADDR     8'h40
`define TMC_CFG_RESET       8'h00
`define TMC_BIT_COUNT       0
`define TMC_EDGE_LO         1
`define TMC_EDGE_HI         2
`define TMC_BIT_SPLIT       3
`define TMC_DIV_LO          4
`define TMC_DIV_HI          6
`define TMC_BIT_ALT         7
`define TMC_SLOW_KHZ        32
`define TMC_SYS_KHZ         20000
`define TMC_MIN_OVERSAMPLE  4
`define TMC_RESP_OKAY       2'b00
`define TMC_RESP_SLVERR     2'b10
`endif

// ==== src/tmc_pkg.sv ====
// Types for the timer mode configuration block
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_EDGE_NONE    = 2'b00,
    TMC_EDGE_RISING  = 2'b01,
    TMC_EDGE_FALLING = 2'b10,
    TMC_EDGE_BOTH    = 2'b11
  } tmc_edge_e;

  typedef struct packed {
    logic      altClockSelect;
    logic [2:0] clockDivideSelect;
    logic      splitModeSelect;
    tmc_edge_e edgeFunctionSelect;
    logic      countModeSelect;
  } tmc_cfg_s;

  typedef struct packed {
    logic highCountEnable;
    logic highCaptureEnable;
    logic highCompareMode;
    logic lowCompareMode;
    logic countRising;
    logic countFalling;
    logic timerTick;
    logic altClockSelect;
  } tmc_ctrl_s;
endpackage : tmc_pkg

// ==== src/tmc_timer_mode_configuration.sv ====
// Timer mode configuration register with AXI4-Lite slave and prescaled timer tick
// Contract
// - Every reset clears configuration register to zero
// - Bit 0: zero timer, one edge counter
// - Counting spans 16 bits, or high byte split
// - Bits 2:1 choose counted input edge
// - Code 00 compare/disabled; others pick edges
// - Split: low byte compare timer, internal clock; timerTick source still follows bit 7 when split
// - Bit 3: zero single 16-bit, one dual
// - Bits 6:4 prescale 1,2,4,8,16,32,64,128
// - Bit 7 selects oversampled 32kHz timer clock
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_timer_mode_configuration
  import tmc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              slowClock,
  output tmc_ctrl_s              ctrl
);
  tmc_cfg_s          cfg_q;
  tmc_cfg_s          cfg_d;
  logic              awHeld_q;
  logic              awHeld_d;
  logic              awReady_q;
  logic              awReady_d;
  logic [ADDR_W-1:0] awAddr_q;
  logic [ADDR_W-1:0] awAddr_d;
  logic              wHeld_q;
  logic              wHeld_d;
  logic              wReady_q;
  logic              wReady_d;
  logic [31:0]       wData_q;
  logic [31:0]       wData_d;
  logic              wLane0_q;
  logic              wLane0_d;
  logic              bValid_q;
  logic              bValid_d;
  logic [1:0]        bResp_q;
  logic [1:0]        bResp_d;
  logic              arReady_q;
  logic              arReady_d;
  logic              rValid_q;
  logic              rValid_d;
  logic [31:0]       rData_q;
  logic [31:0]       rData_d;
  logic [1:0]        rResp_q;
  logic [1:0]        rResp_d;
  logic              slowSync1_q;
  logic              slowSync2_q;
  logic              slowPrev_q;
  logic [6:0]        prescale_q;
  logic [6:0]        prescale_d;
  tmc_ctrl_s         ctrl_d;
  logic              srcTick;

  function automatic logic [6:0] divMask(input logic [2:0] code);
    divMask = 7'((8'h01 << code) - 8'h01);
  endfunction : divMask

  function automatic logic isCfgAddr(input logic [ADDR_W-1:0] addr);
    isCfgAddr = (addr == ADDR_W'(`TMC_CFG_ADDR));
  endfunction : isCfgAddr
  function automatic logic isStatusAddr(input logic [ADDR_W-1:0] addr);
    isStatusAddr = (addr == ADDR_W'(`TMC_STATUS_ADDR));
  endfunction : isStatusAddr

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wLane0_d = wLane0_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    cfg_d    = cfg_q;
    if (s_axi_awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_q) begin
      wHeld_d  = 1'b1;
      wData_d  = s_axi_wdata;
      wLane0_d = s_axi_wstrb[0];
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (awHeld_q && wHeld_q && !bValid_q) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = `TMC_RESP_OKAY;
      if (isCfgAddr(awAddr_q)) begin
        if (wLane0_q) begin
          cfg_d = tmc_cfg_s'(wData_q[7:0]);
        end
      end else if (!isStatusAddr(awAddr_q)) begin
        bResp_d = `TMC_RESP_SLVERR;
      end
    end
    awReady_d = !awHeld_d;
    wReady_d  = !wHeld_d;
  end

  always_comb begin
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (s_axi_arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d  = `TMC_RESP_OKAY;
      rData_d  = 32'h0000_0000;
      if (isCfgAddr(s_axi_araddr)) begin
        rData_d[7:0] = cfg_q;
      end else if (isStatusAddr(s_axi_araddr)) begin
        rData_d[7:0] = ctrl;
      end else begin
        rResp_d = `TMC_RESP_SLVERR;
      end
    end
    arReady_d = !rValid_d;
  end

  always_comb begin
    srcTick    = cfg_q.altClockSelect ? (slowSync2_q && !slowPrev_q) : 1'b1;
    prescale_d = prescale_q;
    ctrl_d     = '0;
    if (srcTick) begin
      if ((prescale_q & divMask(cfg_q.clockDivideSelect)) == divMask(cfg_q.clockDivideSelect)) begin
        prescale_d      = 7'h00;
        ctrl_d.timerTick = 1'b1;
      end else begin
        prescale_d = 7'(prescale_q + 7'h01);
      end
    end
    ctrl_d.altClockSelect    = cfg_q.altClockSelect;
    ctrl_d.highCountEnable   = cfg_q.countModeSelect && (cfg_q.edgeFunctionSelect != TMC_EDGE_NONE);
    ctrl_d.highCaptureEnable = !cfg_q.countModeSelect && (cfg_q.edgeFunctionSelect != TMC_EDGE_NONE);
    ctrl_d.highCompareMode   = !cfg_q.countModeSelect && (cfg_q.edgeFunctionSelect == TMC_EDGE_NONE);
    ctrl_d.lowCompareMode    = cfg_q.splitModeSelect || ctrl_d.highCompareMode;
    ctrl_d.countRising       = cfg_q.edgeFunctionSelect[0];
    ctrl_d.countFalling      = cfg_q.edgeFunctionSelect[1];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q     <= tmc_cfg_s'(`TMC_CFG_RESET);
      awHeld_q  <= 1'b0;
      awReady_q <= 1'b1;
      awAddr_q  <= '0;
      wHeld_q   <= 1'b0;
      wReady_q  <= 1'b1;
      wData_q   <= 32'h0000_0000;
      wLane0_q  <= 1'b0;
      bValid_q  <= 1'b0;
      bResp_q   <= 2'b00;
    end else begin
      cfg_q     <= cfg_d;
      awHeld_q  <= awHeld_d;
      awReady_q <= awReady_d;
      awAddr_q  <= awAddr_d;
      wHeld_q   <= wHeld_d;
      wReady_q  <= wReady_d;
      wData_q   <= wData_d;
      wLane0_q  <= wLane0_d;
      bValid_q  <= bValid_d;
      bResp_q   <= bResp_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= 2'b00;
    end else begin
      arReady_q <= arReady_d;
      rValid_q  <= rValid_d;
      rData_q   <= rData_d;
      rResp_q   <= rResp_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slowSync1_q <= 1'b0;
      slowSync2_q <= 1'b0;
      slowPrev_q  <= 1'b0;
      prescale_q  <= 7'h00;
      ctrl        <= '0;
    end else begin
      slowSync1_q <= slowClock;
      slowSync2_q <= slowSync1_q;
      slowPrev_q  <= slowSync2_q;
      prescale_q  <= prescale_d;
      ctrl        <= ctrl_d;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
endmodule : tmc_timer_mode_configuration
